// ==== design/pchr_config_regs.v ====
// Configuration header register bank with command/status logic.
`timescale 1ns/10ps
`include "pchr_defines.vh"
module pchr_config_regs #(
   parameter [31:0] SIGNATURE = 32'h12345678 // Arbitrary value.
) (
   // Clock and reset.
   input wire i_clk,
   input wire i_rstn,
   // Configuration cycle port.
   input wire i_cfg_wr,
   input wire i_cfg_rd,
   input wire [7:0] i_cfg_addr,
   input wire [3:0] i_cfg_be,
   input wire [31:0] i_cfg_wdata,
   output reg [31:0] o_cfg_rdata,
   // Values loaded from the serial EEPROM.
   input wire i_ee_done,
   input wire [15:0] i_loaded_device_ident,
   input wire [15:0] i_loaded_vendor_ident,
   input wire [31:0] i_ee_subsystem,
   input wire [31:0] i_ee_card_info,
   input wire [15:0] i_ee_lat_gnt,
   input wire i_host_config_ncap,
   // Events from the bus engine.
   input wire i_parity_err,
   input wire i_addr_parity_err,
   input wire i_master_abort,
   input wire i_target_abort,
   input wire i_perr_driven,
   input wire i_perr_seen,
   input wire i_is_master,
   input wire i_sw_reset,
   // Enables and outputs.
   output reg o_serr_drive,
   output reg o_host_sys_err,
   output reg o_bus_master_en,
   output reg o_mem_space_en,
   output reg o_io_space_en,
   output reg o_boot_rom_en
);
   reg [15:0] cmd_r;
   reg perr_r, serr_r, mabt_r, tabt_r, dpr_r;
   reg [31:0] ident_r, subsys_r, cis_r, io_base_address_r, mba_r, brom_r, pm_control_status_r;
   reg [15:0] latcl_r, latgnt_r;
   reg [7:0] intline_r, drv_r;
   reg ee_d1_r, ee_d2_r, ee_d3_r;
   reg ncap_d1_r, ncap_r;
   reg [31:0] rd_nxt, wmask, status_w;
   wire serr_fire = cmd_r[`PCHR_B_SERREN] & i_addr_parity_err;
   wire cyc_wr_cs = i_cfg_wr && i_cfg_addr == `PCHR_OFS_CMDSTAT;

   // Apply byte enables to a write.
   function [31:0] bmerge;
      input [31:0] old;
      input [31:0] wd;
      input [31:0] msk;
      input [3:0] be;
      reg [31:0] m;
      begin
         m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
         bmerge = (old & ~m) | (wd & m);
      end
   endfunction

   // Merged words are kept full width and cut to the register on purpose below.
   wire [31:0] cmd_merge = bmerge({16'h0000, cmd_r}, {16'h0000, i_cfg_wdata[15:0]},
      {16'h0000, `PCHR_CMD_RW_MASK}, i_cfg_be) & {16'h0000, `PCHR_CMD_RW_MASK};
   wire [31:0] lat_merge = bmerge({16'h0000, latcl_r}, i_cfg_wdata,
      32'h0000FFFF, i_cfg_be);

   always @* begin
      wmask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
   end

   // EEPROM done arrives from the loader domain; two stages before use.
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         ee_d1_r <= 1'b0;
         ee_d2_r <= 1'b0;
         ee_d3_r <= 1'b0;
         ncap_d1_r <= 1'b0;
         ncap_r <= 1'b0;
      end else begin
         ee_d1_r <= i_ee_done;
         ee_d2_r <= ee_d1_r;
         ee_d3_r <= ee_d2_r;
         ncap_d1_r <= i_host_config_ncap;
         ncap_r <= ncap_d1_r;
      end
   end

   // Software reset is deliberately not an input to any register here.
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         ident_r <= 32'h00000000;
         subsys_r <= 32'h00000000;
         cis_r <= 32'h00000000;
         latgnt_r <= 16'h0000;
      end else if (ee_d2_r && !ee_d3_r) begin
         ident_r <= {i_loaded_device_ident, i_loaded_vendor_ident};
         subsys_r <= i_ee_subsystem;
         cis_r <= i_ee_card_info;
         latgnt_r <= i_ee_lat_gnt;
      end
   end

   // Command bits and sticky status flags; a set wins over a clear.
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         cmd_r <= 16'h0000;
         perr_r <= 1'b0;
         serr_r <= 1'b0;
         mabt_r <= 1'b0;
         tabt_r <= 1'b0;
         dpr_r <= 1'b0;
         o_serr_drive <= 1'b0;
         o_host_sys_err <= 1'b0;
      end else begin
         if (cyc_wr_cs) begin
            cmd_r <= cmd_merge[15:0];
         end
         o_serr_drive <= serr_fire;
         o_host_sys_err <= cmd_r[`PCHR_B_PERREN] & i_parity_err;
         perr_r <= i_parity_err |
            (perr_r & ~(cyc_wr_cs & wmask[`PCHR_B_PERR] & i_cfg_wdata[`PCHR_B_PERR]));
         serr_r <= o_serr_drive |
            (serr_r & ~(cyc_wr_cs & wmask[`PCHR_B_SERR] & i_cfg_wdata[`PCHR_B_SERR]));
         mabt_r <= (i_master_abort & i_is_master) |
            (mabt_r & ~(cyc_wr_cs & wmask[`PCHR_B_MABT] & i_cfg_wdata[`PCHR_B_MABT]));
         tabt_r <= (i_target_abort & i_is_master) |
            (tabt_r & ~(cyc_wr_cs & wmask[`PCHR_B_TABT] & i_cfg_wdata[`PCHR_B_TABT]));
         dpr_r <= (i_is_master & cmd_r[`PCHR_B_PERREN] & (i_perr_driven | i_perr_seen)) |
            (dpr_r & ~(cyc_wr_cs & wmask[`PCHR_B_DPR] & i_cfg_wdata[`PCHR_B_DPR]));
      end
   end

   // Writable header words; masks keep read-only and reserved bits fixed.
   always @(posedge i_clk) begin
      if (!i_rstn) begin
         latcl_r <= 16'h0000;
         io_base_address_r <= 32'h00000000;
         mba_r <= 32'h00000000;
         brom_r <= 32'h00000000;
         intline_r <= 8'h00;
         drv_r <= 8'h00;
         pm_control_status_r <= 32'h00000000;
      end else if (i_cfg_wr) begin
         case (i_cfg_addr)
            `PCHR_OFS_LATCL: latcl_r <= lat_merge[15:0];
            `PCHR_OFS_IO_BASE_ADDRESS: io_base_address_r <= bmerge(io_base_address_r, i_cfg_wdata, `PCHR_IO_BASE_ADDRESS_MASK, i_cfg_be);
            `PCHR_OFS_MBA: mba_r <= bmerge(mba_r, i_cfg_wdata, `PCHR_MBA_MASK, i_cfg_be);
            `PCHR_OFS_BROM: brom_r <= bmerge(brom_r, i_cfg_wdata, `PCHR_BROM_MASK, i_cfg_be);
            `PCHR_OFS_INTR: intline_r <= i_cfg_be[0] ? i_cfg_wdata[7:0] : intline_r;
            `PCHR_OFS_DRV: drv_r <= i_cfg_be[1] ? i_cfg_wdata[15:8] : drv_r;
            `PCHR_OFS_PM_CONTROL_STATUS: pm_control_status_r <= bmerge(pm_control_status_r, i_cfg_wdata,
               `PCHR_PM_CONTROL_STATUS_MASK, i_cfg_be);
            default: ; // Read-only and reserved words ignore writes
         endcase
      end
   end

   always @* begin
      status_w = 32'h00000000;
      status_w[`PCHR_B_PERR] = perr_r;
      status_w[`PCHR_B_SERR] = serr_r;
      status_w[`PCHR_B_MABT] = mabt_r;
      status_w[`PCHR_B_TABT] = tabt_r;
      status_w[26:25] = `PCHR_DEVSEL;
      status_w[`PCHR_B_DPR] = dpr_r;
      status_w[`PCHR_B_FBB] = 1'b1;
      status_w[`PCHR_B_NCAP] = ncap_r;
      status_w[15:0] = cmd_r;
   end

   always @* begin
      case (i_cfg_addr)
         `PCHR_OFS_IDENT: rd_nxt = ident_r;
         `PCHR_OFS_CMDSTAT: rd_nxt = status_w;
         `PCHR_OFS_CLASS: rd_nxt = `PCHR_CLASS_WORD;
         `PCHR_OFS_LATCL: rd_nxt = {16'h0000, latcl_r};
         `PCHR_OFS_IO_BASE_ADDRESS: rd_nxt = io_base_address_r | `PCHR_IO_BASE_ADDRESS_IND;
         `PCHR_OFS_MBA: rd_nxt = mba_r;
         `PCHR_OFS_CIS: rd_nxt = cis_r;
         `PCHR_OFS_SUBSYS: rd_nxt = subsys_r;
         `PCHR_OFS_BROM: rd_nxt = brom_r;
         `PCHR_OFS_CAPPTR: rd_nxt = `PCHR_CAP_PTR;
         `PCHR_OFS_INTR: rd_nxt = {latgnt_r, `PCHR_INT_PIN, intline_r};
         `PCHR_OFS_DRV: rd_nxt = {16'h0000, drv_r, 8'h00};
         `PCHR_OFS_SIG: rd_nxt = SIGNATURE;
         `PCHR_OFS_PMC: rd_nxt = `PCHR_PMC_WORD;
         `PCHR_OFS_PM_CONTROL_STATUS: rd_nxt = pm_control_status_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge i_clk) begin
      if (!i_rstn) begin
         o_cfg_rdata <= 32'h00000000;
         o_bus_master_en <= 1'b0;
         o_mem_space_en <= 1'b0;
         o_io_space_en <= 1'b0;
         o_boot_rom_en <= 1'b0;
      end else begin
         // Disabled byte lanes read as zero so narrow reads stay clean.
         o_cfg_rdata <= i_cfg_rd ? (rd_nxt & wmask) : 32'h00000000;
         o_bus_master_en <= cmd_r[`PCHR_B_MSTEN];
         o_mem_space_en <= cmd_r[`PCHR_B_MEMEN];
         o_io_space_en <= cmd_r[`PCHR_B_IOEN];
         o_boot_rom_en <= cmd_r[`PCHR_B_MEMEN] & brom_r[0];
      end
   end
endmodule

// ==== inc/pchr_defines.vh ====
// Constants for the configuration header register bank.
// What this block does
// - Word 00h returns loaded device ident high, vendor ident low, read-only.
// - Ident, subsystem, card pointer, latency and grant reload when the synchronised EEPROM done rises.
// - Card information word is read-only; writes leave it unchanged.
// - Driver word bits 15..8 are writable scratch; other bits reserved.
// - Signature word is a fixed constant that ignores writes.
// - Parity error detected flag sets on any i_parity_err, regardless of enable; an address parity error alone does not set it.
// - System error signalled flag sets whenever the device drives SERR# active.
// - Own master transaction master abort sets the master abort flag.
// - Own master transaction target abort sets the target abort flag.
// - Devsel timing field reads constantly 01, read-only.
// - Data parity reported sets only as master, response enabled, PERR# driven or seen.
// - Fast back-to-back capable bit always reads one.
// - New capabilities bit mirrors a bit of the host config register.
// - With serr response enabled, address parity error drives SERR#; enable resets zero.
// - Parity response disabled ignores errors; enabled raises host status system error.
// - Bus master transfers only while master enable is one; resets zero.
// - Memory space accesses answered only while memory enable is one; resets zero.
// - I/O space accesses answered only while I/O enable is one; resets zero.
// - Hardware reset restores defaults; software reset leaves contents unchanged.
// - Byte, word and double word accesses honour byte enables.
`ifndef PCHR_DEFINES_VH
`define PCHR_DEFINES_VH
`define PCHR_OFS_IDENT 8'h00
`define PCHR_OFS_CMDSTAT 8'h04
`define PCHR_OFS_CLASS 8'h08
`define PCHR_OFS_LATCL 8'h0C
`define PCHR_OFS_IO_BASE_ADDRESS 8'h10
`define PCHR_OFS_MBA 8'h14
`define PCHR_OFS_CIS 8'h28
`define PCHR_OFS_SUBSYS 8'h2C
`define PCHR_OFS_BROM 8'h30
`define PCHR_OFS_CAPPTR 8'h34
`define PCHR_OFS_INTR 8'h3C
`define PCHR_OFS_DRV 8'h40
`define PCHR_OFS_SIG 8'h80
`define PCHR_OFS_PMC 8'hC0
`define PCHR_OFS_PM_CONTROL_STATUS 8'hC4
`define PCHR_B_PERR 31
`define PCHR_B_SERR 30
`define PCHR_B_MABT 29
`define PCHR_B_TABT 28
`define PCHR_B_DPR 24
`define PCHR_B_FBB 23
`define PCHR_B_NCAP 20
`define PCHR_B_SERREN 8
`define PCHR_B_PERREN 6
`define PCHR_B_MSTEN 2
`define PCHR_B_MEMEN 1
`define PCHR_B_IOEN 0
`define PCHR_DEVSEL 2'h1
`define PCHR_CLASS_WORD 32'h02000011
`define PCHR_CAP_PTR 32'h000000C0
`define PCHR_INT_PIN 8'h01
`define PCHR_PMC_WORD 32'h00010001
`define PCHR_CMD_RW_MASK 16'h0147
`define PCHR_IO_BASE_ADDRESS_MASK 32'hFFFFFF00
`define PCHR_IO_BASE_ADDRESS_IND 32'h00000001
`define PCHR_MBA_MASK 32'hFFFFFC00
`define PCHR_BROM_MASK 32'hFFFC0001
`define PCHR_DRV_MASK 32'h0000FF00
`define PCHR_PM_CONTROL_STATUS_MASK 32'h00000003
`endif

// ==== testbench/pchr_config_regs_sva.sv ====
// Assertions on the ports of the configuration header register bank.
`timescale 1ns/10ps
module pchr_config_regs_sva #(
   parameter [31:0] SIGNATURE = 32'h12345678 // Arbitrary value.
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_cfg_wr,
   input wire i_cfg_rd,
   input wire [7:0] i_cfg_addr,
   input wire [3:0] i_cfg_be,
   input wire i_parity_err,
   input wire i_addr_parity_err,
   input wire [31:0] o_cfg_rdata,
   input wire o_serr_drive,
   input wire o_host_sys_err
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence status_rd;
      i_cfg_rd && i_cfg_addr == 8'h04 && i_cfg_be[3];
   endsequence
   serr_cause_a: assert property (o_serr_drive |-> $past(i_addr_parity_err))
      else $error("SERR drive without address parity error");
   sys_err_cause_a: assert property (o_host_sys_err |-> $past(i_parity_err))
      else $error("Host system error without parity error");
   rdata_idle_a: assert property (!$past(i_cfg_rd) |-> o_cfg_rdata == 32'h0)
      else $error("Read data not zero outside a read");
   devsel_const_a: assert property (status_rd |=> o_cfg_rdata[26:25] == 2'h1 && o_cfg_rdata[23])
      else $error("Devsel timing or fast back-to-back bit wrong");
   sig_fixed_a: assert property (i_cfg_rd && i_cfg_addr == 8'h80 && i_cfg_be == 4'hF
      |=> o_cfg_rdata == SIGNATURE) else $error("Signature word wrong");
   drv_reserved_a: assert property (i_cfg_rd && i_cfg_addr == 8'h40
      |=> o_cfg_rdata[31:16] == 16'h0 && o_cfg_rdata[7:0] == 8'h0) else $error("Driver word reserved bits set");
   serr_flag_a: assert property (o_serr_drive ##1 status_rd |=> o_cfg_rdata[30])
      else $error("System error flag not set after SERR drive");
   perr_flag_a: assert property (i_parity_err ##1 !i_cfg_wr ##1 status_rd |=> o_cfg_rdata[31])
      else $error("Parity error flag not set");
endmodule
bind pchr_config_regs pchr_config_regs_sva #(.SIGNATURE(SIGNATURE)) u_pchr_config_regs_sva (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
   .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_parity_err(i_parity_err),
   .i_addr_parity_err(i_addr_parity_err), .o_cfg_rdata(o_cfg_rdata),
   .o_serr_drive(o_serr_drive), .o_host_sys_err(o_host_sys_err));

// ==== testbench/pchr_host_model.sv ====
// Host bridge model issuing configuration read and write cycles.
`timescale 1ns/10ps
module pchr_host_model (
   input wire i_clk,
   input wire [31:0] i_rdata,
   output reg o_wr,
   output reg o_rd,
   output reg [7:0] o_addr,
   output reg [3:0] o_be,
   output reg [31:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'hFF;
      o_be = 4'h0;
      o_wdata = 32'h0;
   end
   // Released address and write data show the inverse so stale values cannot pass for valid ones.
   task wr(input [7:0] a, input [3:0] b, input [31:0] d);
      begin
         @(negedge i_clk);
         o_addr = a;
         o_be = b;
         o_wdata = d;
         o_wr = 1'b1;
         @(negedge i_clk);
         o_wr = 1'b0;
         o_addr = ~a;
         o_wdata = ~d;
      end
   endtask
   task rd(input [7:0] a, input [3:0] b, output [31:0] q);
      begin
         @(negedge i_clk);
         o_addr = a;
         o_be = b;
         o_rd = 1'b1;
         @(negedge i_clk);
         o_rd = 1'b0;
         o_addr = ~a;
         q = i_rdata;
      end
   endtask
endmodule

// ==== testbench/pchr_config_regs_bench.sv ====
// Self-checking bench for the configuration header register bank.
`timescale 1ns/10ps
module pchr_config_regs_bench;
   localparam [31:0] SIG = 32'hA5C30F96; // Arbitrary value.
   localparam [31:0] BASE = 32'h02800000;
   localparam [31:0] NCAP = 32'h00100000;
   reg i_clk = 1'b0;
   reg i_rstn = 1'b0;
   reg ee_done = 1'b0;
   reg ncap = 1'b0;
   reg is_master = 1'b0;
   reg sw_reset = 1'b0;
   reg [5:0] ev = 6'h00;
   reg [31:0] q;
   wire wr, rd, serr, sys_err, mst, mem, io, brom;
   wire [7:0] addr;
   wire [3:0] be;
   wire [31:0] wdata, rdata;
   integer err_total = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   always #20 i_clk = ~i_clk;
   pchr_host_model u_pchr_host_model (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_be(be), .o_wdata(wdata));
   pchr_config_regs #(.SIGNATURE(SIG)) u_pchr_config_regs (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata),
      .o_cfg_rdata(rdata), .i_ee_done(ee_done), .i_loaded_device_ident(16'h3C5A),
      .i_loaded_vendor_ident(16'h7E11), .i_ee_subsystem(32'h89AB4D22),
      .i_ee_card_info(32'h00C0FFE3), .i_ee_lat_gnt(16'h2814), .i_host_config_ncap(ncap),
      .i_parity_err(ev[0]), .i_addr_parity_err(ev[1]), .i_master_abort(ev[2]),
      .i_target_abort(ev[3]), .i_perr_driven(ev[4]), .i_perr_seen(ev[5]),
      .i_is_master(is_master), .i_sw_reset(sw_reset), .o_serr_drive(serr),
      .o_host_sys_err(sys_err), .o_bus_master_en(mst), .o_mem_space_en(mem),
      .o_io_space_en(io), .o_boot_rom_en(brom));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task rc(input [7:0] a, input [3:0] b, input [31:0] exp);
      begin
         u_pchr_host_model.rd(a, b, q);
         check(q, exp);
      end
   endtask
   task conclude;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task eeprom_load;
      begin
         @(negedge i_clk);
         ncap = 1'b1;
         ee_done = 1'b1;
         repeat (4) @(negedge i_clk);
         rc(8'h00, 4'hF, 32'h3C5A7E11);
         rc(8'h2C, 4'hF, 32'h89AB4D22);
         u_pchr_host_model.wr(8'h28, 4'hF, 32'h0);
         rc(8'h28, 4'hF, 32'h00C0FFE3);
         rc(8'h3C, 4'hF, 32'h28140100);
         rc(8'h04, 4'hF, BASE | NCAP);
      end
   endtask
   task access_rules;
      begin
         u_pchr_host_model.wr(8'h40, 4'hF, 32'hFFFFFFFF);
         rc(8'h40, 4'hF, 32'h0000FF00);
         u_pchr_host_model.wr(8'h80, 4'hF, 32'h0);
         rc(8'h80, 4'hF, SIG);
         u_pchr_host_model.wr(8'h18, 4'hF, 32'hFFFFFFFF);
         rc(8'h18, 4'hF, 32'h0);
         u_pchr_host_model.wr(8'h04, 4'h1, 32'hFFFFFFFF);
         u_pchr_host_model.wr(8'h04, 4'h2, 32'hFFFFFFFF);
         rc(8'h04, 4'h3, 32'h00000147);
         check({29'h0, mst, mem, io}, 32'h7);
         u_pchr_host_model.wr(8'h30, 4'h1, 32'h00000001);
         @(negedge i_clk);
         check({31'h0, brom}, 32'h1);
      end
   endtask
   task error_flags;
      begin
         is_master = 1'b1;
         @(negedge i_clk);
         ev = 6'h3F;
         @(negedge i_clk);
         ev = 6'h00;
         check({30'h0, serr, sys_err}, 32'h3);
         rc(8'h04, 4'hF, 32'hF3900147);
         u_pchr_host_model.wr(8'h04, 4'h8, 32'hF1000000);
         rc(8'h04, 4'hF, 32'h02900147);
         @(negedge i_clk);
         sw_reset = 1'b1;
         @(negedge i_clk);
         sw_reset = 1'b0;
         rc(8'h04, 4'hF, 32'h02900147);
      end
   endtask
   task reset_again;
      begin
         @(negedge i_clk);
         i_rstn = 1'b0;
         repeat (3) @(negedge i_clk);
         i_rstn = 1'b1;
         repeat (3) @(negedge i_clk);
         rc(8'h04, 4'hF, BASE | NCAP);
         rc(8'h00, 4'hF, 32'h3C5A7E11);
      end
   endtask
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         conclude;
      end
   end
   initial begin
      repeat (3) @(negedge i_clk);
      i_rstn = 1'b1;
      rc(8'h04, 4'hF, BASE);
      eeprom_load;
      access_rules;
      error_flags;
      reset_again;
      conclude;
   end
endmodule
